// ---- shared/osf_defs.vh ----
/*
 * Register offsets, field positions, reset values and fixed thresholds
 * for the orientation status / filter configuration register slice.
 * Assumes inclusion by bare name from design files under hdl/.
 */
`ifndef OSF_DEFS_VH
`define OSF_DEFS_VH

// register offsets (8-bit register space)
`define OSF_ADDR_W              8
`define OSF_OFS_HP_CUTOFF       8'h0f
`define OSF_OFS_ORIENT_STATUS   8'h10
`define OSF_OFS_ORIENT_CONFIG   8'h11

// highpass_cutoff_config fields
`define OSF_HP_BYPASS_BIT       5
`define OSF_HP_LOWPASS_BIT      4
`define OSF_HP_SEL_HI           1
`define OSF_HP_SEL_LO           0
`define OSF_HP_BYPASS_RST       1'b0
`define OSF_HP_LOWPASS_RST      1'b0
`define OSF_HP_SEL_RST          2'h0

// orientation_status fields
`define OSF_ST_CHANGE_BIT       7
`define OSF_ST_LOCK_BIT         6
`define OSF_ST_PL_HI            2
`define OSF_ST_PL_LO            1
`define OSF_ST_BF_BIT           0
`define OSF_PL_RST              2'h0
`define OSF_BF_RST              1'b0
`define OSF_LOCK_RST            1'b0

// orientation_config fields
`define OSF_CFG_DBMODE_BIT      7
`define OSF_CFG_ENABLE_BIT      6
`define OSF_CFG_DBMODE_RST      1'b1
`define OSF_CFG_ENABLE_RST      1'b0

// portrait/landscape encodings
`define OSF_PL_PORTRAIT_UP      2'h0
`define OSF_PL_PORTRAIT_DOWN    2'h1
`define OSF_PL_LANDSCAPE_RIGHT  2'h2
`define OSF_PL_LANDSCAPE_LEFT   2'h3

// oversampling modes
`define OSF_MODE_NORMAL         2'h0
`define OSF_MODE_LOWNOISE_LP    2'h1
`define OSF_MODE_HIGHRES        2'h2
`define OSF_MODE_LOWPOWER       2'h3

// output sample rate codes
`define OSF_RATE_800            3'h0
`define OSF_RATE_400            3'h1
`define OSF_RATE_200            3'h2
`define OSF_RATE_100            3'h3
`define OSF_RATE_50             3'h4
`define OSF_RATE_12P5           3'h5
`define OSF_RATE_6P25           3'h6
`define OSF_RATE_1P56           3'h7

// cut-off is 16 Hz shifted right by this many places
`define OSF_SHIFT_W             4
`define OSF_SHIFT_LNLP_SLOW     4'h5
`define OSF_SHIFT_LP_SLOW       4'h6

// full-scale codes and 1.25g limits in 12-bit counts
`define OSF_FS_2G               2'h0
`define OSF_FS_4G               2'h1
`define OSF_LIMIT_2G            12'h500
`define OSF_LIMIT_4G            12'h280
`define OSF_LIMIT_8G            12'h140

`endif

// ---- hdl/osf_cutoff_sel.v ----
/*
 * High-pass cut-off selection: maps cut-off code, oversampling mode and
 * output sample rate to a right shift applied to 16 Hz.
 * Assumes all inputs are stable register values on the caller's clock.
 */
`timescale 1ns/1ns
`include "osf_defs.vh"

module osf_cutoff_sel (
	input  wire [1:0]                  cutoff_sel,
	input  wire [1:0]                  oversample_mode,
	input  wire [2:0]                  output_sample_rate,
	output reg  [`OSF_SHIFT_W-1:0]     cutoff_shift
);

	reg [`OSF_SHIFT_W-1:0] rate_shift;

	always @* begin
		rate_shift = {`OSF_SHIFT_W{1'b0}};
		case (oversample_mode)
			`OSF_MODE_HIGHRES: begin
				rate_shift = {`OSF_SHIFT_W{1'b0}};
			end
			`OSF_MODE_LOWPOWER: begin
				if (output_sample_rate >= `OSF_RATE_12P5)
					rate_shift = `OSF_SHIFT_LP_SLOW;
				else
					rate_shift = {1'b0, output_sample_rate};
			end
			default: begin
				if (output_sample_rate <= `OSF_RATE_400)
					rate_shift = {`OSF_SHIFT_W{1'b0}};
				else if (output_sample_rate <= `OSF_RATE_50)
					rate_shift = {1'b0, output_sample_rate} - 4'h1;
				else if (oversample_mode == `OSF_MODE_LOWNOISE_LP)
					rate_shift = `OSF_SHIFT_LNLP_SLOW;
				else
					rate_shift = 4'h3;
			end
		endcase
		cutoff_shift = rate_shift + {2'h0, cutoff_sel};
	end

endmodule // osf_cutoff_sel

// ---- hdl/osf_orient_regs.v ----
/*
 * Orientation status / configuration and high-pass filter configuration
 * registers, with change flagging, clear-on-read and overload hold.
 * Assumes register access strobes and orientation results come from logic
 * on the same clock; one strobe per cycle, read data one cycle later.
 */
`timescale 1ns/1ns
`include "osf_defs.vh"

// Summary of operation
// - bypass bit skips tap high-pass, resets 0
// - lowpass bit inserts tap low-pass, resets 0
// - two-bit cut-off code, resets 00
// - normal mode cut-off table by rate
// - low-noise mode: slower rates drop further
// - low-power mode halves per rate step down to 50, fixed at rates 12.5 and below
// - status read clears change flag
// - flag on first result or field change
// - portrait/landscape encoding, resets 00
// - back/front bit: 0 front, resets 0
// - tilt lockout bit, resets 0
// - fields keep updating while flag set
// - hold result when any axis exceeds 1.25g
// - status bit layout, 5:3 read zero
// - config layout: mode, enable, zeros
// - debounce mode resets 1, enable 0
// - irq source follows flag and enable
module osf_orient_regs (
	input  wire                        clk,
	input  wire                        rst_n,
	input  wire [`OSF_ADDR_W-1:0]      reg_addr,
	input  wire                        reg_wr,
	input  wire [7:0]                  reg_wdata,
	input  wire                        reg_rd,
	output reg  [7:0]                  reg_rdata_r,
	input  wire                        active_mode,
	input  wire [1:0]                  oversample_mode,
	input  wire [2:0]                  output_sample_rate,
	input  wire [1:0]                  full_scale,
	input  wire signed [11:0]          axis_x,
	input  wire signed [11:0]          axis_y,
	input  wire signed [11:0]          axis_z,
	input  wire                        orient_result_valid,
	input  wire [1:0]                  orient_result_pl,
	input  wire                        orient_result_bf,
	input  wire                        orient_result_lock,
	input  wire                        orient_irq_enable,
	output reg                         tap_highpass_bypass_r,
	output reg                         tap_lowpass_enable_r,
	output reg  [1:0]                  hp_cutoff_sel_r,
	output reg  [`OSF_SHIFT_W-1:0]     hp_cutoff_shift_r,
	output reg                         debounce_mode_select_r,
	output reg                         orient_detect_enable_r,
	output reg                         orient_change_flag_r,
	output reg                         z_tilt_guard_flag_r,
	output reg  [1:0]                  portrait_landscape_state_r,
	output reg                         back_front_state_r,
	output reg                         orient_irq_source_r
);

	reg                        active_d_r;
	reg                        active_rise;
	reg                        first_pending_r;
	reg                        first_pending_nxt;
	reg                        change_nxt;
	reg                        accept;
	reg                        differs;
	reg  [11:0]                limit;
	reg  [11:0]                mag_x;
	reg  [11:0]                mag_y;
	reg  [11:0]                mag_z;
	reg                        overload;
	reg  [7:0]                 rdata_nxt;
	wire [`OSF_SHIFT_W-1:0]    shift_w;
	wire                       wr_hp;
	wire                       wr_cfg;
	wire                       rd_status;

	assign wr_hp     = reg_wr && (reg_addr == `OSF_OFS_HP_CUTOFF);
	assign wr_cfg    = reg_wr && (reg_addr == `OSF_OFS_ORIENT_CONFIG);
	assign rd_status = reg_rd && (reg_addr == `OSF_OFS_ORIENT_STATUS);

	osf_cutoff_sel u_cutoff (
		.cutoff_sel         (hp_cutoff_sel_r),
		.oversample_mode    (oversample_mode),
		.output_sample_rate (output_sample_rate),
		.cutoff_shift       (shift_w)
	);

	// overload check against 1.25g at current full scale
	always @* begin
		case (full_scale)
			`OSF_FS_2G: limit = `OSF_LIMIT_2G;
			`OSF_FS_4G: limit = `OSF_LIMIT_4G;
			default:    limit = `OSF_LIMIT_8G;
		endcase
		mag_x = axis_x[11] ? (~axis_x + 12'h001) : axis_x;
		mag_y = axis_y[11] ? (~axis_y + 12'h001) : axis_y;
		mag_z = axis_z[11] ? (~axis_z + 12'h001) : axis_z;
		if (axis_x == 12'h800)
			mag_x = 12'h7ff;
		if (axis_y == 12'h800)
			mag_y = 12'h7ff;
		if (axis_z == 12'h800)
			mag_z = 12'h7ff;
		overload = (mag_x > limit) || (mag_y > limit) || (mag_z > limit);
	end

	// change detection and flag next values
	always @* begin
		accept  = orient_result_valid && orient_detect_enable_r && active_mode && !overload;
		differs = (orient_result_pl != portrait_landscape_state_r) ||
		          (orient_result_bf != back_front_state_r) ||
		          (orient_result_lock != z_tilt_guard_flag_r);
		active_rise = active_mode && !active_d_r;
		first_pending_nxt = first_pending_r;
		if (!active_mode)
			first_pending_nxt = 1'b0;
		else if (accept)
			first_pending_nxt = 1'b0;
		else if (active_rise)
			first_pending_nxt = 1'b1;
		change_nxt = orient_change_flag_r;
		if (rd_status)
			change_nxt = 1'b0;
		if (accept && (first_pending_r || active_rise || differs))
			change_nxt = 1'b1;
	end

	// read data mux
	always @* begin
		rdata_nxt = 8'h00;
		case (reg_addr)
			`OSF_OFS_HP_CUTOFF: begin
				rdata_nxt[`OSF_HP_BYPASS_BIT]               = tap_highpass_bypass_r;
				rdata_nxt[`OSF_HP_LOWPASS_BIT]              = tap_lowpass_enable_r;
				rdata_nxt[`OSF_HP_SEL_HI:`OSF_HP_SEL_LO]    = hp_cutoff_sel_r;
			end
			`OSF_OFS_ORIENT_STATUS: begin
				rdata_nxt[`OSF_ST_CHANGE_BIT]               = orient_change_flag_r;
				rdata_nxt[`OSF_ST_LOCK_BIT]                 = z_tilt_guard_flag_r;
				rdata_nxt[`OSF_ST_PL_HI:`OSF_ST_PL_LO]      = portrait_landscape_state_r;
				rdata_nxt[`OSF_ST_BF_BIT]                   = back_front_state_r;
			end
			`OSF_OFS_ORIENT_CONFIG: begin
				rdata_nxt[`OSF_CFG_DBMODE_BIT]              = debounce_mode_select_r;
				rdata_nxt[`OSF_CFG_ENABLE_BIT]              = orient_detect_enable_r;
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			tap_highpass_bypass_r      <= `OSF_HP_BYPASS_RST;
			tap_lowpass_enable_r       <= `OSF_HP_LOWPASS_RST;
			hp_cutoff_sel_r            <= `OSF_HP_SEL_RST;
			hp_cutoff_shift_r          <= {`OSF_SHIFT_W{1'b0}};
			debounce_mode_select_r     <= `OSF_CFG_DBMODE_RST;
			orient_detect_enable_r     <= `OSF_CFG_ENABLE_RST;
			orient_change_flag_r       <= 1'b0;
			z_tilt_guard_flag_r        <= `OSF_LOCK_RST;
			portrait_landscape_state_r <= `OSF_PL_RST;
			back_front_state_r         <= `OSF_BF_RST;
			orient_irq_source_r        <= 1'b0;
			active_d_r                 <= 1'b0;
			first_pending_r            <= 1'b0;
			reg_rdata_r                <= 8'h00;
		end else begin
			if (wr_hp) begin
				tap_highpass_bypass_r <= reg_wdata[`OSF_HP_BYPASS_BIT];
				tap_lowpass_enable_r  <= reg_wdata[`OSF_HP_LOWPASS_BIT];
				hp_cutoff_sel_r       <= reg_wdata[`OSF_HP_SEL_HI:`OSF_HP_SEL_LO];
			end
			if (wr_cfg) begin
				debounce_mode_select_r <= reg_wdata[`OSF_CFG_DBMODE_BIT];
				orient_detect_enable_r <= reg_wdata[`OSF_CFG_ENABLE_BIT];
			end
			hp_cutoff_shift_r <= shift_w;
			if (accept) begin
				portrait_landscape_state_r <= orient_result_pl;
				back_front_state_r         <= orient_result_bf;
				z_tilt_guard_flag_r        <= orient_result_lock;
			end
			orient_change_flag_r <= change_nxt;
			orient_irq_source_r  <= change_nxt && orient_irq_enable;
			active_d_r           <= active_mode;
			first_pending_r      <= first_pending_nxt;
			if (reg_rd)
				reg_rdata_r <= rdata_nxt;
		end
	end

endmodule // osf_orient_regs

// ---- tb/osf_orient_regs_chk.sv ----
/* checker for osf_orient_regs ports, bound below.
   assumes single clk domain, rst_n synchronous active low. */
`timescale 1ns/1ns
module osf_orient_regs_chk (
	input wire       clk,
	input wire       rst_n,
	input wire [7:0] reg_addr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata_r,
	input wire       active_mode,
	input wire       orient_result_valid,
	input wire [1:0] orient_result_pl,
	input wire       orient_irq_enable,
	input wire       debounce_mode_select_r,
	input wire       orient_detect_enable_r,
	input wire       orient_change_flag_r,
	input wire       z_tilt_guard_flag_r,
	input wire [1:0] portrait_landscape_state_r,
	input wire       back_front_state_r,
	input wire       orient_irq_source_r
);
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
wire [3:0] fld = {z_tilt_guard_flag_r, portrait_landscape_state_r, back_front_state_r};
sequence s_st_rd;
	reg_rd && reg_addr == 8'h10;
endsequence
AST_RST_VAL: assert property ($rose(rst_n) |-> debounce_mode_select_r
	&& !orient_detect_enable_r && !orient_change_flag_r && fld == 4'h0)
	else $error("reset values wrong");
AST_ST_RD: assert property (s_st_rd |=> reg_rdata_r == {$past(orient_change_flag_r),
	$past(z_tilt_guard_flag_r), 3'h0, $past(portrait_landscape_state_r),
	$past(back_front_state_r)}) else $error("status read data wrong");
AST_CFG_RD: assert property (reg_rd && reg_addr == 8'h11 |=> reg_rdata_r ==
	{$past(debounce_mode_select_r), $past(orient_detect_enable_r), 6'h00})
	else $error("config read data wrong");
AST_RD_CLR: assert property (s_st_rd and !orient_result_valid |=> !orient_change_flag_r)
	else $error("flag not cleared by read");
AST_FLAG_KEEP: assert property (orient_change_flag_r && !(reg_rd && reg_addr == 8'h10)
	|=> orient_change_flag_r) else $error("flag lost without read");
AST_IRQ: assert property (orient_irq_source_r ==
	(orient_change_flag_r && $past(orient_irq_enable))) else $error("irq source wrong");
AST_CHG_FLAG: assert property ($changed(fld) |-> orient_change_flag_r)
	else $error("field change without flag");
AST_CHG_SRC: assert property ($changed(fld) |-> $past(orient_result_valid) &&
	$past(orient_result_pl) == portrait_landscape_state_r) else $error("field change uncaused");
AST_HOLD: assert property (!orient_result_valid || !active_mode || !orient_detect_enable_r
	|=> $stable(fld)) else $error("fields moved while idle");
endmodule // osf_orient_regs_chk
bind osf_orient_regs osf_orient_regs_chk chk_i (.*);

// ---- tb/osf_host_model.sv ----
/* host model: byte register access strobes.
   assumes one clk; released lines show inverted last value. */
`timescale 1ns/1ns
module osf_host_model (
	input  wire       clk,
	input  wire [7:0] rdata,
	output reg  [7:0] addr,
	output reg  [7:0] wdata,
	output reg        wr,
	output reg        rd
);
initial begin
	addr = 8'hff;
	wdata = 8'h00;
	wr = 1'b0;
	rd = 1'b0;
end
task write(input [7:0] a, input [7:0] v);
	begin
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~v;
	end
endtask
task read(input [7:0] a, output [7:0] v);
	begin
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		#1 v = rdata;
	end
endtask
endmodule // osf_host_model

// ---- tb/osf_orient_regs_tb.sv ----
/* self-checking bench for osf_orient_regs.
   assumes 125 MHz clk, host model drives the register strobes. */
`timescale 1ns/1ns
module osf_orient_regs_tb;
reg               clk = 0, rst_n = 0, act = 0, vld = 0, bf = 0, lk = 0, ien = 0;
reg        [1:0]  om = 0, fs = 0, pl = 0;
reg        [2:0]  rt = 0;
reg signed [11:0] ax = 0, ay = 0, az = 0;
reg        [7:0]  d;
wire       [7:0]  a, wd, rdd;
wire              wr, rd, bp, lp, dm, en, fl, lo, bfs, irq;
wire       [1:0]  hs, pls;
wire       [3:0]  sh;
integer           n_fail = 0, comparisons = 0, m, r, s, e;
osf_host_model h (.clk(clk), .rdata(rdd), .addr(a), .wdata(wd), .wr(wr), .rd(rd));
osf_orient_regs uut (.clk(clk), .rst_n(rst_n), .reg_addr(a), .reg_wr(wr), .reg_wdata(wd),
	.reg_rd(rd), .reg_rdata_r(rdd), .active_mode(act), .oversample_mode(om),
	.output_sample_rate(rt), .full_scale(fs), .axis_x(ax), .axis_y(ay), .axis_z(az),
	.orient_result_valid(vld), .orient_result_pl(pl), .orient_result_bf(bf),
	.orient_result_lock(lk), .orient_irq_enable(ien), .tap_highpass_bypass_r(bp),
	.tap_lowpass_enable_r(lp), .hp_cutoff_sel_r(hs), .hp_cutoff_shift_r(sh),
	.debounce_mode_select_r(dm), .orient_detect_enable_r(en), .orient_change_flag_r(fl),
	.z_tilt_guard_flag_r(lo), .portrait_landscape_state_r(pls), .back_front_state_r(bfs),
	.orient_irq_source_r(irq));
initial begin
	forever #4 clk = ~clk;
end
task chk(input [63:0] nm, input [15:0] got, input [15:0] exp);
	begin
		comparisons = comparisons + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("unexpected %0s exp %h got %h", nm, exp, got);
		end
	end
endtask
task report_and_stop;
	begin
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
endtask
task send(input [1:0] p, input b, input l);
	begin
		@(posedge clk);
		vld <= 1;
		pl <= p;
		bf <= b;
		lk <= l;
		@(posedge clk);
		vld <= 0;
		#1;
	end
endtask
initial begin
	repeat (20000) @(posedge clk);
	n_fail = n_fail + 1;
	report_and_stop;
end
initial begin
	repeat (8) @(posedge clk);
	rst_n <= 1;
	@(posedge clk);
	#1 chk("dbm", dm, 1);
	chk("rst", {bp, lp, hs, en, fl, lo, pls, bfs, irq}, 0);
	h.read(8'h0f, d); chk("hp", d, 0);
	h.read(8'h10, d); chk("st", d, 0);
	h.read(8'h11, d); chk("cfg", d, 8'h80);
	h.write(8'h0f, 8'hff); h.read(8'h0f, d); chk("hp", d, 8'h33);
	chk("bplp", {bp, lp, hs}, 4'hf);
	h.write(8'h11, 8'hff); h.read(8'h11, d); chk("cfg", d, 8'hc0);
	h.write(8'h10, 8'hff); h.read(8'h10, d); chk("st", d, 0);
	h.read(8'h20, d); chk("unmap", d, 0);
	for (m = 0; m < 4; m = m + 1) for (r = 0; r < 8; r = r + 1) for (s = 0; s < 4; s = s + 1) begin
		@(posedge clk) om <= m;
		rt <= r;
		h.write(8'h0f, s);
		@(posedge clk);
		e = (r < 2) ? 0 : (r > 4) ? 3 : r - 1;
		if (m == 1 && r > 4) e = 5;
		if (m == 2) e = 0;
		if (m == 3) e = (r > 4) ? 6 : r;
		#1 chk("shift", sh, s + e);
	end
	@(posedge clk) act <= 1;
	ien <= 1;
	send(0, 0, 0); chk("first", {fl, irq}, 2'h3);
	h.read(8'h10, d); chk("st", d, 8'h80);
	chk("clr", {fl, irq}, 0);
	send(0, 0, 0); chk("same", fl, 0);
	for (s = 1; s < 4; s = s + 1) send(s, 1, 1);
	h.read(8'h10, d); chk("st", d, 8'hc7);
	@(posedge clk) ax <= 12'sd1281;
	send(0, 0, 0); chk("hold", {lo, pls, bfs}, 4'hf);
	@(posedge clk) ax <= 0;
	az <= -12'sd1280;
	send(1, 0, 1); chk("limit", {lo, pls, bfs}, 4'ha);
	h.read(8'h10, d);
	@(posedge clk) ien <= 0;
	send(2, 1, 0); chk("noirq", {fl, irq}, 2'h2);
	h.read(8'h10, d);
	@(posedge clk) act <= 0;
	send(3, 0, 0); chk("stby", {fl, pls}, 3'h2);
	@(posedge clk) act <= 1;
	send(2, 1, 0); chk("wake", fl, 1);
	h.write(8'h11, 8'h80);
	send(0, 0, 0); chk("off", pls, 2);
	h.write(8'h11, 8'h40); h.read(8'h11, d); chk("cfg", d, 8'h40);
	fork
		send(1, 0, 0);
		h.read(8'h10, d);
	join
	chk("both", {d, fl}, 9'h10b);
	h.read(8'h10, d); chk("st", d, 8'h82);
	@(posedge clk) fs <= 1;
	az <= -12'sd641;
	send(3, 0, 0); chk("fs4", {fl, pls}, 3'h1);
	@(posedge clk) fs <= 2;
	az <= 12'sd320;
	send(3, 0, 0); chk("fs8", {fl, pls}, 3'h7);
	h.read(8'h10, d); chk("st", d, 8'h86);
	@(posedge clk) act <= 0;
	fork
		@(posedge clk) act <= 1;
		send(3, 0, 0);
	join
	chk("rise", fl, 1);
	report_and_stop;
end
endmodule // osf_orient_regs_tb
